/* common/pcm_pkg.sv */
// Constants, types and helpers for the PWM/counter register map.
// Assumes a Modbus front end that hands over one decoded access at a time.
package pcm_pkg;

  localparam int PCM_CH = 8;

  // Reference numbers, one flat 16-bit space
  localparam logic [15:0] PCM_COIL_RUN      = 16'h0001;
  localparam logic [15:0] PCM_COIL_OVF      = 16'h0041;
  localparam logic [15:0] PCM_COIL_CNT_EN   = 16'h00e1;
  localparam logic [15:0] PCM_COIL_PROTO    = 16'h0101;
  localparam logic [15:0] PCM_COIL_WD_MODE  = 16'h0104;
  localparam logic [15:0] PCM_COIL_WD_EN    = 16'h0105;
  localparam logic [15:0] PCM_COIL_CLR_CNT  = 16'h010a;
  localparam logic [15:0] PCM_COIL_WD_TO    = 16'h010e;
  localparam logic [15:0] PCM_COIL_IN_POL   = 16'h0116;
  localparam logic [15:0] PCM_COIL_SAVE     = 16'h0121;
  localparam logic [15:0] PCM_COIL_TRIG_EN  = 16'h0381;
  localparam logic [15:0] PCM_COIL_TRIG_GO  = 16'h03a1;
  localparam logic [15:0] PCM_COIL_SYNC     = 16'h03c1;
  localparam logic [15:0] PCM_DIN_LEVEL     = 16'h2731;
  localparam logic [15:0] PCM_DIN_FIRST_RD  = 16'h2821;
  localparam logic [15:0] PCM_IN_CNT_VAL    = 16'h7531;
  localparam logic [15:0] PCM_IN_FW_LO      = 16'h7711;
  localparam logic [15:0] PCM_IN_FW_HI      = 16'h7712;
  localparam logic [15:0] PCM_IN_NAME_LO    = 16'h7713;
  localparam logic [15:0] PCM_IN_NAME_HI    = 16'h7714;
  localparam logic [15:0] PCM_IN_BURST_RB   = 16'h7831;
  localparam logic [15:0] PCM_HR_CNT_MAX    = 16'h9c81;
  localparam logic [15:0] PCM_HR_PRESET     = 16'h9ca1;
  localparam logic [15:0] PCM_HR_NODE       = 16'h9e25;
  localparam logic [15:0] PCM_HR_FMT        = 16'h9e26;
  localparam logic [15:0] PCM_HR_DELAY      = 16'h9e28;
  localparam logic [15:0] PCM_HR_WD_VAL     = 16'h9e29;
  localparam logic [15:0] PCM_HR_LED_CFG    = 16'h9e2f;
  localparam logic [15:0] PCM_HR_LED_DATA   = 16'h9e30;
  localparam logic [15:0] PCM_HR_PWR_DOWN   = 16'h9e32;
  localparam logic [15:0] PCM_HR_DUTY       = 16'h9f01;
  localparam logic [15:0] PCM_HR_FREQ       = 16'h9f21;
  localparam logic [15:0] PCM_HR_BURST      = 16'h9f61;

  // Field positions and limits
  localparam int          PCM_FMT_BAUD_MSB  = 5;
  localparam int          PCM_FMT_FRAME_LSB = 6;
  localparam logic [15:0] PCM_NODE_MIN      = 16'h0001;
  localparam logic [15:0] PCM_NODE_MAX      = 16'h00f7;
  localparam logic [5:0]  PCM_BAUD_MIN      = 6'h03;
  localparam logic [5:0]  PCM_BAUD_MAX      = 6'h0a;
  localparam logic [15:0] PCM_DELAY_MAX     = 16'h001e;
  localparam logic [15:0] PCM_WD_VAL_MAX    = 16'h00ff;

  // Values after reset and factory defaults
  localparam logic        PCM_FIRST_RD_RST  = 1'b1;
  localparam logic [7:0]  PCM_DEF_NODE      = 8'h00;
  localparam logic [5:0]  PCM_DEF_BAUD      = 6'h06;
  localparam logic [1:0]  PCM_DEF_FRAME     = 2'h0;
  localparam logic        PCM_DEF_CHECKSUM  = 1'b0;
  localparam logic [16:0] PCM_BAUD_9600     = 17'h02580;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic [15:0] addr;
    logic [15:0] wdata;
  } pcm_req_t;

  typedef struct packed {
    logic        valid;
    logic        error;
    logic [15:0] data;
  } pcm_rsp_t;

  typedef struct packed {
    logic [7:0]  nodeAddr;
    logic [5:0]  baudCode;
    logic [1:0]  frame;
    logic        checksumEn;
    logic        protoSel;
  } pcm_nv_cfg_t;

  typedef struct packed {
    logic [7:0]  nodeAddr;
    logic [5:0]  baudCode;
    logic [16:0] baud;
    logic        parityEn;
    logic        parityOdd;
    logic        twoStop;
    logic        checksumEn;
    logic [4:0]  respDelayMs;
  } pcm_link_cfg_t;

  typedef struct packed {
    logic [7:0]        pwmRun;
    logic [7:0]        cntEn;
    logic [7:0]        trigEn;
    logic [7:0]        trigStart;
    logic [7:0]        sync;
    logic              inPolarity;
    logic              protoSel;
    logic              wdEn;
    logic              wdMode;
    logic [7:0]        wdTimeoutVal;
    logic [15:0]       ledCfg;
    logic [15:0]       ledData;
    logic [15:0]       powerDown;
    logic [7:0][15:0]  duty;
    logic [7:0][31:0]  freq;
    logic [7:0][15:0]  burstSteps;
    logic [7:0][31:0]  cntMax;
    logic [7:0][31:0]  cntPreset;
  } pcm_ctrl_t;

  typedef struct packed {
    logic [7:0]        ovfEvent;
    logic              wdTimeoutEvent;
    logic              outputCmd;
    logic [7:0]        inputLevel;
    logic [7:0]        burstMode;
    logic [7:0][15:0]  burstCount;
    logic [7:0][31:0]  count;
  } pcm_status_in_t;

  // Line rate for a baud code; zero for codes outside the table
  function automatic logic [16:0] pcm_baud(input logic [5:0] code);
    case (code)
      6'h03:   return 17'h004b0;
      6'h04:   return 17'h00960;
      6'h05:   return 17'h012c0;
      6'h06:   return 17'h02580;
      6'h07:   return 17'h04b00;
      6'h08:   return 17'h09600;
      6'h09:   return 17'h0e100;
      6'h0a:   return 17'h1c200;
      default: return 17'h00000;
    endcase
  endfunction : pcm_baud

endpackage : pcm_pkg

/* core/pcm_register_map.sv */
// Register map of the eight-channel PWM and input counter module.
// Assumes the Modbus framer delivers one access per request pulse and
// that counter, PWM and storage logic sit around this block.
// Behaviour
// RQ1: Overflow flags stick until written one
// RQ2: Clear coil zeroes every input counter
// RQ3: Watchdog timeout readable, write one clears
// RQ4: Save coil stores all PWM configuration
// RQ5: Reset flag reads one once after power-on
// RQ6: Count is low word then high word
// RQ7: Each counter has writable low/high preset
// RQ8: Burst readback valid only bursting and stopped
// RQ9: Node address accepts only 1 to 247
// RQ10: Format bits 5:0 pick line rate
// RQ11: Format bits 7:6 pick parity and stops
// RQ12: Response delay 0 to 30 ms
// RQ13: Watchdog timeout 0 to 255 tenths
// RQ14: Mode one lets output commands clear timeout
// RQ15: Frequency is 32 bits, low word first
// RQ16: Strap low uses defaults, storage untouched
// RQ17: Defaults: address 0, 9600, no checksum, 8N1
// RQ18: Strap high configures from stored settings
// RQ19: Default mode echoes stored configuration
// RQ20: Channel n at base+n, paired at base+2n
`timescale 1ns/10ps

module pcm_register_map
  import pcm_pkg::*;
#(
  parameter logic [15:0] FW_VER_LO  = 16'h0100, // arbitrary value
  parameter logic [15:0] FW_VER_HI  = 16'h0000, // arbitrary value
  parameter logic [15:0] NAME_LO    = 16'h1234, // arbitrary value
  parameter logic [15:0] NAME_HI    = 16'h0000  // arbitrary value
)(
  input  wire logic           clk_sys,
  input  wire logic           rst_n,
  input  wire logic           initStrap_n,
  input  wire pcm_nv_cfg_t    nvCfg,
  input  wire pcm_req_t       req,
  input  wire pcm_status_in_t stat,
  output pcm_rsp_t            rsp,
  output pcm_ctrl_t           ctrl,
  output pcm_link_cfg_t       link,
  output pcm_nv_cfg_t         nvEcho,
  output logic [7:0]          ovfFlag,
  output logic                wdTimedOut,
  output logic                clearCounters,
  output logic                savePwmConfig,
  output logic                initMode,
  output logic                ready
);

  typedef struct packed {
    pcm_ctrl_t     ctrl;
    pcm_link_cfg_t link;
    pcm_nv_cfg_t   nvEcho;
    pcm_rsp_t      rsp;
    logic [7:0]    ovf;
    logic          wdTimedOut;
    logic          firstRead;
    logic          initMode;
    logic          loaded;
    logic          clearCnt;
    logic          savePwm;
  } pcm_state_t;

  pcm_state_t st;
  pcm_state_t next_st;

  function automatic logic isHit(input logic [15:0] a, input logic [15:0] b,
                                 input int n);
    return (a >= b) && ({16'h0000, a} < {16'h0000, b} + n[31:0]);
  endfunction : isHit

  // Channel index, optionally for paired words
  function automatic logic [2:0] chanOf(input logic [15:0] a,
                                        input logic [15:0] b,
                                        input logic pair);
    logic [15:0] d;
    d = a - b;
    return pair ? d[3:1] : d[2:0];
  endfunction : chanOf

  function automatic pcm_link_cfg_t linkOf(input logic [7:0] node,
                                           input logic [5:0] code,
                                           input logic [1:0] frame,
                                           input logic csum,
                                           input logic [4:0] dly);
    pcm_link_cfg_t l;
    l.nodeAddr    = node;
    l.baudCode    = code;
    l.baud        = pcm_baud(code);
    l.parityEn    = frame[1];
    l.parityOdd   = frame[1] & frame[0];
    l.twoStop     = ~frame[1] & frame[0];
    l.checksumEn  = csum;
    l.respDelayMs = dly;
    return l;
  endfunction : linkOf

  logic        wr;
  logic        w0;
  logic [15:0] a;
  logic [15:0] w;
  logic        hiWord;

  assign wr     = req.valid & req.write;
  assign w0     = req.wdata[0];
  assign a      = req.addr;
  assign w      = req.wdata;
  assign hiWord = a[0] ^ PCM_IN_CNT_VAL[0];

  always_comb
  begin
    logic [2:0]  c;
    logic [7:0]  ovfClr;
    logic        wdClr;
    logic [15:0] d;
    logic        err;
    c       = 3'h0;
    ovfClr  = 8'h00;
    wdClr   = 1'b0;
    d       = 16'h0000;
    err     = 1'b0;
    next_st = st;
    next_st.rsp      = '0;
    next_st.clearCnt = 1'b0;
    next_st.savePwm  = 1'b0;
    if (!st.loaded)
    begin
      next_st.loaded   = 1'b1;
      next_st.initMode = ~initStrap_n;
      next_st.nvEcho   = nvCfg;
      next_st.ctrl.protoSel = nvCfg.protoSel;
      // RQ16 RQ17 factory defaults
      if (!initStrap_n)
        next_st.link = linkOf(PCM_DEF_NODE, PCM_DEF_BAUD, PCM_DEF_FRAME,
                              PCM_DEF_CHECKSUM, 5'h00);
      // RQ18 stored settings
      else
        next_st.link = linkOf(nvCfg.nodeAddr, nvCfg.baudCode, nvCfg.frame,
                              nvCfg.checksumEn, 5'h00);
    end
    else if (req.valid)
    begin
      next_st.rsp.valid = 1'b1;
      // RQ20 coil banks per channel
      if (isHit(a, PCM_COIL_RUN, PCM_CH))
      begin
        c = chanOf(a, PCM_COIL_RUN, 1'b0);
        d = {15'h0000, st.ctrl.pwmRun[c]};
        if (wr) next_st.ctrl.pwmRun[c] = w0;
      end
      else if (isHit(a, PCM_COIL_OVF, PCM_CH))
      begin
        c = chanOf(a, PCM_COIL_OVF, 1'b0);
        d = {15'h0000, st.ovf[c]};
        // RQ1 write one clears
        ovfClr[c] = wr & w0;
      end
      else if (isHit(a, PCM_COIL_CNT_EN, PCM_CH))
      begin
        c = chanOf(a, PCM_COIL_CNT_EN, 1'b0);
        d = {15'h0000, st.ctrl.cntEn[c]};
        if (wr) next_st.ctrl.cntEn[c] = w0;
      end
      else if (isHit(a, PCM_COIL_TRIG_EN, PCM_CH))
      begin
        c = chanOf(a, PCM_COIL_TRIG_EN, 1'b0);
        d = {15'h0000, st.ctrl.trigEn[c]};
        if (wr) next_st.ctrl.trigEn[c] = w0;
      end
      else if (isHit(a, PCM_COIL_TRIG_GO, PCM_CH))
      begin
        c = chanOf(a, PCM_COIL_TRIG_GO, 1'b0);
        d = {15'h0000, st.ctrl.trigStart[c]};
        if (wr) next_st.ctrl.trigStart[c] = w0;
      end
      else if (isHit(a, PCM_COIL_SYNC, PCM_CH))
      begin
        c = chanOf(a, PCM_COIL_SYNC, 1'b0);
        d = {15'h0000, st.ctrl.sync[c]};
        if (wr) next_st.ctrl.sync[c] = w0;
      end
      else if (a == PCM_COIL_PROTO)
      begin
        d = {15'h0000, st.ctrl.protoSel};
        if (wr) next_st.ctrl.protoSel = w0;
      end
      else if (a == PCM_COIL_WD_MODE)
      begin
        d = {15'h0000, st.ctrl.wdMode};
        if (wr) next_st.ctrl.wdMode = w0;
      end
      else if (a == PCM_COIL_WD_EN)
      begin
        d = {15'h0000, st.ctrl.wdEn};
        if (wr) next_st.ctrl.wdEn = w0;
      end
      else if (a == PCM_COIL_IN_POL)
      begin
        d = {15'h0000, st.ctrl.inPolarity};
        if (wr) next_st.ctrl.inPolarity = w0;
      end
      // RQ2 clear all counters
      else if (a == PCM_COIL_CLR_CNT)
        next_st.clearCnt = wr;
      // RQ3 timeout flag
      else if (a == PCM_COIL_WD_TO)
      begin
        d     = {15'h0000, st.wdTimedOut};
        wdClr = wr & w0;
      end
      // RQ4 save configuration
      else if (a == PCM_COIL_SAVE)
        next_st.savePwm = wr & w0;
      else if (isHit(a, PCM_DIN_LEVEL, PCM_CH))
      begin
        d   = {15'h0000, stat.inputLevel[chanOf(a, PCM_DIN_LEVEL, 1'b0)]};
        err = wr;
      end
      // RQ5 first read after power-on
      else if (a == PCM_DIN_FIRST_RD)
      begin
        d   = {15'h0000, st.firstRead};
        err = wr;
        if (!wr) next_st.firstRead = 1'b0;
      end
      // RQ6 count words
      else if (isHit(a, PCM_IN_CNT_VAL, 2 * PCM_CH))
      begin
        c   = chanOf(a, PCM_IN_CNT_VAL, 1'b1);
        d   = hiWord ? stat.count[c][31:16] : stat.count[c][15:0];
        err = wr;
      end
      // RQ8 burst readback condition
      else if (isHit(a, PCM_IN_BURST_RB, PCM_CH))
      begin
        c   = chanOf(a, PCM_IN_BURST_RB, 1'b0);
        d   = (stat.burstMode[c] && !st.ctrl.pwmRun[c]) ?
              stat.burstCount[c] : 16'h0000;
        err = wr;
      end
      else if (a == PCM_IN_FW_LO || a == PCM_IN_FW_HI ||
               a == PCM_IN_NAME_LO || a == PCM_IN_NAME_HI)
      begin
        d   = (a == PCM_IN_FW_LO) ? FW_VER_LO :
              (a == PCM_IN_FW_HI) ? FW_VER_HI :
              (a == PCM_IN_NAME_LO) ? NAME_LO : NAME_HI;
        err = wr;
      end
      else if (isHit(a, PCM_HR_CNT_MAX, 2 * PCM_CH))
      begin
        c = chanOf(a, PCM_HR_CNT_MAX, 1'b1);
        d = hiWord ? st.ctrl.cntMax[c][31:16] : st.ctrl.cntMax[c][15:0];
        if (wr && hiWord) next_st.ctrl.cntMax[c][31:16] = w;
        if (wr && !hiWord) next_st.ctrl.cntMax[c][15:0] = w;
      end
      // RQ7 preset words
      else if (isHit(a, PCM_HR_PRESET, 2 * PCM_CH))
      begin
        c = chanOf(a, PCM_HR_PRESET, 1'b1);
        d = hiWord ? st.ctrl.cntPreset[c][31:16] :
            st.ctrl.cntPreset[c][15:0];
        if (wr && hiWord) next_st.ctrl.cntPreset[c][31:16] = w;
        if (wr && !hiWord) next_st.ctrl.cntPreset[c][15:0] = w;
      end
      // RQ15 frequency words
      else if (isHit(a, PCM_HR_FREQ, 2 * PCM_CH))
      begin
        c = chanOf(a, PCM_HR_FREQ, 1'b1);
        d = hiWord ? st.ctrl.freq[c][31:16] : st.ctrl.freq[c][15:0];
        if (wr && hiWord) next_st.ctrl.freq[c][31:16] = w;
        if (wr && !hiWord) next_st.ctrl.freq[c][15:0] = w;
      end
      else if (isHit(a, PCM_HR_DUTY, PCM_CH))
      begin
        c = chanOf(a, PCM_HR_DUTY, 1'b0);
        d = st.ctrl.duty[c];
        if (wr) next_st.ctrl.duty[c] = w;
      end
      else if (isHit(a, PCM_HR_BURST, PCM_CH))
      begin
        c = chanOf(a, PCM_HR_BURST, 1'b0);
        d = st.ctrl.burstSteps[c];
        if (wr) next_st.ctrl.burstSteps[c] = w;
      end
      // RQ9 node address range
      else if (a == PCM_HR_NODE)
      begin
        d   = {8'h00, st.link.nodeAddr};
        err = wr && (w < PCM_NODE_MIN || w > PCM_NODE_MAX);
        if (wr && !err) next_st.link.nodeAddr = w[7:0];
      end
      // RQ10 RQ11 line rate and framing
      else if (a == PCM_HR_FMT)
      begin
        d   = {8'h00,
               st.link.parityEn, st.link.parityOdd | st.link.twoStop,
               st.link.baudCode};
        err = wr && (w[15:8] != 8'h00 ||
                     w[PCM_FMT_BAUD_MSB:0] < PCM_BAUD_MIN ||
                     w[PCM_FMT_BAUD_MSB:0] > PCM_BAUD_MAX);
        if (wr && !err)
          next_st.link = linkOf(st.link.nodeAddr, w[PCM_FMT_BAUD_MSB:0],
                                w[PCM_FMT_FRAME_LSB+1:PCM_FMT_FRAME_LSB],
                                st.link.checksumEn, st.link.respDelayMs);
      end
      // RQ12 response delay
      else if (a == PCM_HR_DELAY)
      begin
        d   = {11'h000, st.link.respDelayMs};
        err = wr && (w > PCM_DELAY_MAX);
        if (wr && !err) next_st.link.respDelayMs = w[4:0];
      end
      // RQ13 watchdog timeout value
      else if (a == PCM_HR_WD_VAL)
      begin
        d   = {8'h00, st.ctrl.wdTimeoutVal};
        err = wr && (w > PCM_WD_VAL_MAX);
        if (wr && !err) next_st.ctrl.wdTimeoutVal = w[7:0];
      end
      else if (a == PCM_HR_LED_CFG)
      begin
        d = st.ctrl.ledCfg;
        if (wr) next_st.ctrl.ledCfg = w;
      end
      else if (a == PCM_HR_LED_DATA)
      begin
        d = st.ctrl.ledData;
        if (wr) next_st.ctrl.ledData = w;
      end
      else if (a == PCM_HR_PWR_DOWN)
      begin
        d = st.ctrl.powerDown;
        if (wr) next_st.ctrl.powerDown = w;
      end
      else
        err = 1'b1;
      next_st.rsp.data  = d;
      next_st.rsp.error = err;
    end
    // RQ14 output command clears timeout
    if (stat.outputCmd && st.ctrl.wdMode)
      wdClr = 1'b1;
    // RQ1 RQ3 a new event beats a clear
    next_st.ovf        = (st.ovf & ~ovfClr) | stat.ovfEvent;
    next_st.wdTimedOut = (st.wdTimedOut & ~wdClr) | stat.wdTimeoutEvent;
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      st           <= '0;
      st.firstRead <= PCM_FIRST_RD_RST;
    end
    else
      st <= next_st;
  end

  assign rsp           = st.rsp;
  assign ctrl          = st.ctrl;
  assign link          = st.link;
  // RQ19 stored configuration echo
  assign nvEcho        = st.initMode ? st.nvEcho : '0;
  assign ovfFlag       = st.ovf;
  assign wdTimedOut    = st.wdTimedOut;
  assign clearCounters = st.clearCnt;
  assign savePwmConfig = st.savePwm;
  assign initMode      = st.initMode;
  assign ready         = st.loaded;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  sequence sWrCoil(logic [15:0] adr);
    st.loaded && wr && a == adr && w0;
  endsequence

  sequence sReadFirst;
    st.loaded && req.valid && !req.write && a == PCM_DIN_FIRST_RD;
  endsequence

  AST_OVF_SET: assert property ( // RQ1
    (|stat.ovfEvent) |=> ((ovfFlag & $past(stat.ovfEvent)) ==
                          $past(stat.ovfEvent)))
    else $error("overflow event lost");
  AST_OVF_HOLD: assert property ( // RQ1
    !(st.loaded && wr && isHit(a, PCM_COIL_OVF, PCM_CH))
    |=> ((ovfFlag & $past(ovfFlag)) == $past(ovfFlag)))
    else $error("overflow flag dropped without clear");
  AST_CLR_CNT: assert property ( // RQ2
    st.loaded && wr && a == PCM_COIL_CLR_CNT |=> clearCounters ##1
    (!clearCounters || $past(wr && a == PCM_COIL_CLR_CNT)))
    else $error("clear counters pulse wrong");
  AST_WD_CLR: assert property ( // RQ3
    sWrCoil(PCM_COIL_WD_TO) ##0 !stat.wdTimeoutEvent |=> !wdTimedOut)
    else $error("timeout flag not cleared");
  AST_SAVE: assert property ( // RQ4
    savePwmConfig |-> $past(st.loaded && wr && a == PCM_COIL_SAVE && w0))
    else $error("save pulse without cause");
  AST_FIRST_RD: assert property ( // RQ5
    sReadFirst ##2 sReadFirst |=> rsp.valid && rsp.data == 16'h0000)
    else $error("reset flag read twice as set");
  AST_NODE: assert property ( // RQ9
    st.loaded && wr && a == PCM_HR_NODE && w > PCM_NODE_MAX
    |=> rsp.error && $stable(link.nodeAddr))
    else $error("node address out of range taken");
  AST_WD_AUTO: assert property ( // RQ14
    stat.outputCmd && ctrl.wdMode && !stat.wdTimeoutEvent |=> !wdTimedOut)
    else $error("output command did not clear timeout");
  AST_BURST: assert property ( // RQ8
    st.loaded && req.valid && !req.write &&
    isHit(a, PCM_IN_BURST_RB, PCM_CH) && ctrl.pwmRun[a[2:0] - 3'h1]
    |=> rsp.data == 16'h0000)
    else $error("burst readback while running");
  AST_DEFAULTS: assert property ( // RQ17
    $rose(ready) && initMode |-> link.nodeAddr == PCM_DEF_NODE &&
    link.baud == PCM_BAUD_9600 && !link.checksumEn && !link.parityEn)
    else $error("factory defaults not applied");

endmodule : pcm_register_map

/* bench/pcm_host_model.sv */
// Host side model issuing one register access at a time.
// Assumes the register map answers one cycle after taking a request.
`timescale 1ns/10ps

module pcm_host_model
  import pcm_pkg::*;
(
  input  wire logic     clk_sys,
  input  wire logic     ready,
  input  wire pcm_rsp_t rsp,
  output pcm_req_t      req
);

  initial
  begin
    req = '0;
  end

  // One access; err is unknown when no answer came
  task automatic acc(input logic w, input logic [15:0] a, d,
                     output logic [15:0] q, output logic err);
    do
    begin
      @(posedge clk_sys);
      #1;
    end
    while (ready !== 1'b1);
    req = '{1'b1, w, a, d};
    @(posedge clk_sys);
    #1;
    q   = rsp.data;
    err = (rsp.valid === 1'b1) ? rsp.error : 1'bx;
    // Released lines show the inverse of the last value
    req = '{1'b0, ~w, ~a, ~d};
  endtask : acc

endmodule : pcm_host_model

/* bench/pcm_register_map_tb.sv */
// Self-checking bench for the register map.
// Assumes the host model drives every request.
`timescale 1ns/10ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin num_errors++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end

module pcm_register_map_tb
  import pcm_pkg::*;
;
  logic           clk_sys;
  logic           rst_n;
  logic           initStrap_n;
  pcm_nv_cfg_t    nvCfg;
  pcm_req_t       req;
  pcm_status_in_t stat;
  pcm_rsp_t       rsp;
  pcm_ctrl_t      ctrl;
  pcm_link_cfg_t  link;
  pcm_nv_cfg_t    nvEcho;
  logic [7:0]     ovfFlag;
  logic           wdTimedOut;
  logic           clearCounters;
  logic           savePwmConfig;
  logic           initMode;
  logic           ready;
  int             num_errors;
  int             checks_done;
  logic [16:0]    bt [8];
  logic [5:0]     code;
  logic [2:0]     fr [4];

  pcm_register_map pcm_register_map_inst (.clk_sys(clk_sys), .rst_n(rst_n),
    .initStrap_n(initStrap_n), .nvCfg(nvCfg), .req(req), .stat(stat),
    .rsp(rsp), .ctrl(ctrl), .link(link), .nvEcho(nvEcho),
    .ovfFlag(ovfFlag), .wdTimedOut(wdTimedOut),
    .clearCounters(clearCounters), .savePwmConfig(savePwmConfig),
    .initMode(initMode), .ready(ready));

  pcm_host_model pcm_host_model_inst (.clk_sys(clk_sys), .ready(ready),
    .rsp(rsp), .req(req));

  initial
  begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  task automatic tally_and_finish;
    $display("errors=%0d checks=%0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : tally_and_finish

  task automatic wr(input logic [15:0] a, d, input logic ee);
    logic [15:0] q;
    logic        er;
    pcm_host_model_inst.acc(1'b1, a, d, q, er);
    `CHK(er, ee)
  endtask : wr

  task automatic rd(input logic [15:0] a, ed);
    logic [15:0] q;
    logic        er;
    pcm_host_model_inst.acc(1'b0, a, 16'h0000, q, er);
    `CHK({er, q}, {1'b0, ed})
  endtask : rd

  task automatic rst(input logic strap);
    @(posedge clk_sys);
    #1;
    rst_n       = 1'b0;
    initStrap_n = strap;
    repeat (2) @(posedge clk_sys);
    #1;
    rst_n = 1'b1;
    @(posedge clk_sys);
    #1;
  endtask : rst

  // Pulse 0..7 overflow, 8 timeout, 9 output command
  task automatic ev(input int k);
    @(posedge clk_sys);
    #1;
    if (k < 8)
      stat.ovfEvent[k] = 1'b1;
    else if (k == 8)
      stat.wdTimeoutEvent = 1'b1;
    else
      stat.outputCmd = 1'b1;
    @(posedge clk_sys);
    #1;
    stat.ovfEvent       = 8'h00;
    stat.wdTimeoutEvent = 1'b0;
    stat.outputCmd      = 1'b0;
  endtask : ev

  initial
  begin
    #20000;
    num_errors++;
    tally_and_finish();
  end

  initial
  begin
    rst_n = 1'b0;
    initStrap_n = 1'b1;
    nvCfg = '{8'h12, 6'h07, 2'h3, 1'b1, 1'b1};
    stat = '0;
    num_errors = 0;
    checks_done = 0;
    bt = '{17'h004b0, 17'h00960, 17'h012c0, 17'h02580,
           17'h04b00, 17'h09600, 17'h0e100, 17'h1c200};
    fr = '{3'h0, 3'h1, 3'h4, 3'h6};
    rst(1'b1);
    `CHK(link.nodeAddr, 8'h12)
    `CHK(link.baud, 17'h04b00)
    `CHK({link.parityOdd, initMode, nvEcho}, {2'h2, 18'h0})
    rd(PCM_DIN_FIRST_RD, 16'h0001);
    rd(PCM_DIN_FIRST_RD, 16'h0000);
    wr(PCM_HR_NODE, 16'h0000, 1'b1);
    wr(PCM_HR_NODE, 16'h00f8, 1'b1);
    wr(PCM_HR_NODE, 16'h0001, 1'b0);
    wr(PCM_HR_NODE, 16'h00f7, 1'b0);
    `CHK(link.nodeAddr, 8'hf7)
    rd(PCM_HR_NODE, 16'h00f7);
    for (int i = 0; i < 8; i++)
    begin
      code = 6'(i + 3);
      wr(PCM_HR_FMT, {8'h00, code[1:0], code}, 1'b0);
      `CHK(link.baud, bt[i])
      `CHK({link.parityEn, link.parityOdd, link.twoStop}, fr[code[1:0]])
    end
    wr(PCM_HR_FMT, 16'h0002, 1'b1);
    rd(PCM_HR_FMT, 16'h008a);
    wr(PCM_HR_DELAY, 16'h001e, 1'b0);
    `CHK(link.respDelayMs, 5'h1e)
    wr(PCM_HR_DELAY, 16'h001f, 1'b1);
    wr(PCM_HR_WD_VAL, 16'h00ff, 1'b0);
    `CHK(ctrl.wdTimeoutVal, 8'hff)
    wr(PCM_HR_WD_VAL, 16'h0100, 1'b1);
    wr(16'h0050, 16'h0001, 1'b1);
    wr(PCM_DIN_LEVEL, 16'h0001, 1'b1);
    wr(PCM_HR_DUTY + 16'h0002, 16'h0321, 1'b0);
    `CHK(ctrl.duty[2], 16'h0321)
    ev(3);
    `CHK(ovfFlag, 8'h08)
    rd(PCM_COIL_OVF + 16'h0003, 16'h0001);
    wr(PCM_COIL_OVF + 16'h0003, 16'h0000, 1'b0);
    `CHK(ovfFlag, 8'h08)
    wr(PCM_COIL_OVF + 16'h0003, 16'h0001, 1'b0);
    `CHK(ovfFlag, 8'h00)
    wr(PCM_COIL_CLR_CNT, 16'h0001, 1'b0);
    `CHK(clearCounters, 1'b1)
    wr(PCM_COIL_SAVE, 16'h0001, 1'b0);
    `CHK(savePwmConfig, 1'b1)
    ev(8);
    ev(9);
    `CHK(wdTimedOut, 1'b1)
    wr(PCM_COIL_WD_MODE, 16'h0001, 1'b0);
    ev(9);
    `CHK(wdTimedOut, 1'b0)
    ev(8);
    rd(PCM_COIL_WD_TO, 16'h0001);
    wr(PCM_COIL_WD_TO, 16'h0001, 1'b0);
    `CHK(wdTimedOut, 1'b0)
    stat.count[2] = 32'h89abcdef;
    rd(PCM_IN_CNT_VAL + 16'h0004, 16'hcdef);
    rd(PCM_IN_CNT_VAL + 16'h0005, 16'h89ab);
    wr(PCM_HR_PRESET + 16'h0002, 16'h5678, 1'b0);
    wr(PCM_HR_PRESET + 16'h0003, 16'h1234, 1'b0);
    `CHK(ctrl.cntPreset[1], 32'h12345678)
    wr(PCM_HR_FREQ + 16'h000e, 16'hbeef, 1'b0);
    wr(PCM_HR_FREQ + 16'h000f, 16'h0001, 1'b0);
    `CHK(ctrl.freq[7], 32'h0001beef)
    stat.burstMode[5] = 1'b1;
    stat.burstCount[5] = 16'h0abc;
    rd(PCM_IN_BURST_RB + 16'h0005, 16'h0abc);
    wr(PCM_COIL_RUN + 16'h0005, 16'h0001, 1'b0);
    rd(PCM_IN_BURST_RB + 16'h0005, 16'h0000);
    rst(1'b0);
    `CHK({link.nodeAddr, link.baud}, {8'h00, 17'h02580})
    `CHK({link.checksumEn, link.parityEn, link.twoStop, initMode}, 4'h1)
    `CHK({nvEcho, savePwmConfig}, {nvCfg, 1'b0})
    rd(PCM_DIN_FIRST_RD, 16'h0001);
    tally_and_finish();
  end

endmodule : pcm_register_map_tb
